// >>> shared/pin_control_defines.vh
// Overview of operation
// - Port B pin is input when its direction bit is zero, output when one.
// - Port B direction bits without a pin read zero and ignore writes.
// - Reset clears port B direction, so all port B pins start as inputs.
// - Slow-edge enable resets to zero; acts on open-drain port B pins only as outputs.
// - Upper open-drain pin falls sharply half a cycle late; middle pin slews slowly.
// - With the pull option built in, a pin pulls when its pull bit is zero.
// - Pulldowns act only on inputs; pullups act whenever enabled, any direction.
// - Port B pull register is write-only; it reads as zero.
// - After reset every pin is an input with its optional pull device active.
// - Direction registers hold eight bits for port A and three for port B.
// - Direction bits are plain read/write bits, safe for read-modify-write.
// - A port A output pin, or the port B push-pull output pin, is driven to the level of its data bit.
// - Reading data of output pins returns the stored latch bit, not the pin.
// - Reading data of input pins returns the sampled pin level.
// - Writing data of an input pin updates the latch but not the pin.
// - Reset leaves both data registers alone and clears the port A pull register.
`ifndef PIN_CONTROL_DEFINES_VH
`define PIN_CONTROL_DEFINES_VH

// ----------------------------------------------------------------------------
// Register indices; the bus byte address is four times the index.
// ----------------------------------------------------------------------------
`define IDX_W          6
`define IDX_PA_DATA    6'h00
`define IDX_PB_DATA    6'h01
`define IDX_PA_DIR     6'h04
`define IDX_PB_DIR     6'h05
`define IDX_PA_PULL    6'h10
`define IDX_PB_PULL    6'h11

// ----------------------------------------------------------------------------
// Field layout.
// ----------------------------------------------------------------------------
`define PA_W           8
`define PB_W           3
`define SLOW_BIT       7
`define PB_UPPER_OD    2
`define PB_MIDDLE_OD   1
`define PB_PUSH_PULL   0

// ----------------------------------------------------------------------------
// Reset values.
// ----------------------------------------------------------------------------
`define PA_DIR_RST     8'h00
`define PB_DIR_RST     3'h0
`define PA_PULL_RST    8'h00
`define PB_PULL_RST    3'h0
`define SLOW_RST       1'b0

// ----------------------------------------------------------------------------
// Slow upper-pin fall delay: half a bus cycle, at least one clock.
// ----------------------------------------------------------------------------
`define SLOW_DLY_CYC   1

`endif

// >>> hdl/dual_port_pin_control.v
// The implementer's own choice: register access over AHB-Lite.
`timescale 1ns/10ps
`include "pin_control_defines.vh"

module dual_port_pin_control #(
  parameter [`PA_W-1:0] PA_PULL_PRESENT = 8'hFF,
  parameter [`PA_W-1:0] PA_PULL_IS_UP   = 8'h00,
  parameter [`PB_W-1:0] PB_PULL_PRESENT = 3'h7,
  parameter [`PB_W-1:0] PB_PULL_IS_UP   = 3'h6
) (
  // Clock and reset.
  input  wire             sys_clk_i,
  input  wire             rst_i,
  // AHB-Lite slave.
  input  wire             hsel_i,
  input  wire [7:0]       haddr_i,
  input  wire [1:0]       htrans_i,
  input  wire             hwrite_i,
  input  wire [2:0]       hsize_i,
  input  wire [31:0]      hwdata_i,
  input  wire             hready_i,
  output reg  [31:0]      hrdata_o,
  output reg              hreadyout_o,
  output reg              hresp_o,
  // Port A pins.
  input  wire [`PA_W-1:0] port_a_pin_data_pins_i,
  output reg  [`PA_W-1:0] port_a_pin_data_pins_o,
  output reg  [`PA_W-1:0] port_a_pin_data_pins_oe_n_o,
  output reg  [`PA_W-1:0] port_a_pin_data_pull_on_o,
  // Port B pins.
  input  wire [`PB_W-1:0] port_b_pin_data_pins_i,
  output reg  [`PB_W-1:0] port_b_pin_data_pins_o,
  output reg  [`PB_W-1:0] port_b_pin_data_pins_oe_n_o,
  output reg  [`PB_W-1:0] port_b_pin_data_pull_on_o,
  output reg              port_b_pin_data_slow_slew_o
);

  // --------------------------------------------------------------------------
  // Register state.
  // --------------------------------------------------------------------------
  reg  [`PA_W-1:0]  pa_data;
  reg  [`PB_W-1:0]  pb_data;
  reg  [`PA_W-1:0]  port_a_direction;
  reg  [`PB_W-1:0]  port_b_direction;
  reg               slow_edge_enable;
  reg  [`PA_W-1:0]  port_a_pull_select;
  reg  [`PB_W-1:0]  port_b_pull_select;

  reg  [`PA_W-1:0]  next_pa_data;
  reg  [`PB_W-1:0]  next_pb_data;
  reg  [`PA_W-1:0]  next_pa_dir;
  reg  [`PB_W-1:0]  next_pb_dir;
  reg               next_slow;
  reg  [`PA_W-1:0]  next_pa_pull;
  reg  [`PB_W-1:0]  next_pb_pull;

  // --------------------------------------------------------------------------
  // Bus phase tracking.
  // --------------------------------------------------------------------------
  reg               wr_pend;
  reg  [`IDX_W-1:0] wr_idx;
  wire              addr_take;
  wire              rd_take;
  wire              word_ok;
  wire [`IDX_W-1:0] rd_idx;
  reg  [31:0]       next_rdata;

  // --------------------------------------------------------------------------
  // Register strobes: writes act in the data phase, reads in the address phase.
  // --------------------------------------------------------------------------
  wire              wr_pa_data;
  wire              wr_pb_data;
  wire              wr_pa_dir;
  wire              wr_pb_dir;
  wire              wr_pa_pull;
  wire              wr_pb_pull;
  wire              rd_pa_data;
  wire              rd_pb_data;
  wire              rd_pa_dir;
  wire              rd_pb_dir;

  // --------------------------------------------------------------------------
  // Pin sampling and drive.
  // --------------------------------------------------------------------------
  wire [`PA_W-1:0]  pa_lvl;
  wire [`PB_W-1:0]  pb_lvl;
  wire [`PA_W-1:0]  pa_pull_want;
  wire [`PB_W-1:0]  pb_pull_want;
  wire              push_out;
  wire              middle_low;

  reg               upper_low_dly;
  wire              upper_low;

  assign addr_take = hsel_i & htrans_i[1] & hready_i;
  assign rd_take   = addr_take & ~hwrite_i;
  assign word_ok   = (haddr_i[1:0] == 2'b00);
  assign rd_idx    = haddr_i[7:2];

  // --------------------------------------------------------------------------
  // Write strobes.
  // --------------------------------------------------------------------------
  assign wr_pa_data = wr_pend & (wr_idx == `IDX_PA_DATA);
  assign wr_pb_data = wr_pend & (wr_idx == `IDX_PB_DATA);
  assign wr_pa_dir  = wr_pend & (wr_idx == `IDX_PA_DIR);
  assign wr_pb_dir  = wr_pend & (wr_idx == `IDX_PB_DIR);
  assign wr_pa_pull = wr_pend & (wr_idx == `IDX_PA_PULL);
  assign wr_pb_pull = wr_pend & (wr_idx == `IDX_PB_PULL);

  // --------------------------------------------------------------------------
  // Read selects. Misaligned or unmapped reads select nothing and give zero.
  // --------------------------------------------------------------------------
  assign rd_pa_data = word_ok & (rd_idx == `IDX_PA_DATA);
  assign rd_pb_data = word_ok & (rd_idx == `IDX_PB_DATA);
  assign rd_pa_dir  = word_ok & (rd_idx == `IDX_PA_DIR);
  assign rd_pb_dir  = word_ok & (rd_idx == `IDX_PB_DIR);

  // --------------------------------------------------------------------------
  // Address phase capture.
  // --------------------------------------------------------------------------
  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      wr_pend     <= 1'b0;
      wr_idx      <= {`IDX_W{1'b0}};
      hreadyout_o <= 1'b1;
      hresp_o     <= 1'b0;
    end else begin
      wr_pend     <= addr_take & hwrite_i & word_ok;
      wr_idx      <= haddr_i[7:2];
      hreadyout_o <= 1'b1;
      hresp_o     <= 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // Register write data phase, computed as next values.
  // --------------------------------------------------------------------------
  always @* begin
    next_pa_data = pa_data;
    next_pb_data = pb_data;
    next_pa_dir  = port_a_direction;
    next_pb_dir  = port_b_direction;
    next_slow    = slow_edge_enable;
    next_pa_pull = port_a_pull_select;
    next_pb_pull = port_b_pull_select;
    if (wr_pa_data) begin
      next_pa_data = hwdata_i[`PA_W-1:0];
    end
    if (wr_pb_data) begin
      next_pb_data = hwdata_i[`PB_W-1:0];
    end
    if (wr_pa_dir) begin
      next_pa_dir = hwdata_i[`PA_W-1:0];
    end
    if (wr_pb_dir) begin
      next_pb_dir = hwdata_i[`PB_W-1:0];
      next_slow   = hwdata_i[`SLOW_BIT];
    end
    if (wr_pa_pull) begin
      next_pa_pull = hwdata_i[`PA_W-1:0];
    end
    if (wr_pb_pull) begin
      next_pb_pull = hwdata_i[`PB_W-1:0];
    end
  end

  // The data latches have no reset: their contents survive a reset.
  always @(posedge sys_clk_i) begin
    pa_data <= next_pa_data;
    pb_data <= next_pb_data;
  end

  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      port_a_direction   <= `PA_DIR_RST;
      port_b_direction   <= `PB_DIR_RST;
      slow_edge_enable   <= `SLOW_RST;
      port_a_pull_select <= `PA_PULL_RST;
      port_b_pull_select <= `PB_PULL_RST;
    end else begin
      port_a_direction   <= next_pa_dir;
      port_b_direction   <= next_pb_dir;
      slow_edge_enable   <= next_slow;
      port_a_pull_select <= next_pa_pull;
      port_b_pull_select <= next_pb_pull;
    end
  end

  // --------------------------------------------------------------------------
  // Read mux. It looks at next values so that a read straight after a write
  // to the same register already sees the new contents.
  // --------------------------------------------------------------------------
  always @* begin
    next_rdata = 32'h0000_0000;
    // Pull registers are write-only and, like unmapped words, read as zero.
    if (rd_pa_data) begin
      next_rdata[`PA_W-1:0] = (next_pa_dir & next_pa_data) |
                              (~next_pa_dir & pa_lvl);
    end
    if (rd_pb_data) begin
      next_rdata[`PB_W-1:0] = (next_pb_dir & next_pb_data) |
                              (~next_pb_dir & pb_lvl);
    end
    if (rd_pa_dir) begin
      next_rdata[`PA_W-1:0] = next_pa_dir;
    end
    if (rd_pb_dir) begin
      next_rdata[`PB_W-1:0] = next_pb_dir;
      next_rdata[`SLOW_BIT] = next_slow;
    end
  end

  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      hrdata_o <= 32'h0000_0000;
    end else if (rd_take) begin
      hrdata_o <= next_rdata;
    end else begin
      hrdata_o <= 32'h0000_0000;
    end
  end

  // --------------------------------------------------------------------------
  // Pin input sampling, one sampler per port.
  // --------------------------------------------------------------------------
  pin_sampler #(
    .W (`PA_W)
  ) port_a_pin_data_sampler (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .pins_i    (port_a_pin_data_pins_i),
    .level_o   (pa_lvl)
  );

  pin_sampler #(
    .W (`PB_W)
  ) port_b_pin_data_sampler (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .pins_i    (port_b_pin_data_pins_i),
    .level_o   (pb_lvl)
  );

  // --------------------------------------------------------------------------
  // Pin drive. Open-drain pins only ever pull low; a high level is a release.
  // --------------------------------------------------------------------------
  assign upper_low  = port_b_direction[`PB_UPPER_OD] & ~pb_data[`PB_UPPER_OD];
  // The middle pin sinks at once; its slow slope comes from the pad.
  assign middle_low = port_b_direction[`PB_MIDDLE_OD] & ~pb_data[`PB_MIDDLE_OD];
  assign push_out   = port_b_direction[`PB_PUSH_PULL] & pb_data[`PB_PUSH_PULL];

  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      upper_low_dly <= 1'b0;
    end else begin
      upper_low_dly <= upper_low;
    end
  end

  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      port_a_pin_data_pins_o      <= {`PA_W{1'b0}};
      port_a_pin_data_pins_oe_n_o <= {`PA_W{1'b1}};
      port_b_pin_data_pins_o      <= {`PB_W{1'b0}};
      port_b_pin_data_pins_oe_n_o <= {`PB_W{1'b1}};
      port_b_pin_data_slow_slew_o <= 1'b0;
    end else begin
      port_a_pin_data_pins_o      <= port_a_direction & pa_data;
      port_a_pin_data_pins_oe_n_o <= ~port_a_direction;
      port_b_pin_data_pins_o      <= {`PB_W{1'b0}};
      port_b_pin_data_pins_o[`PB_PUSH_PULL] <= push_out;
      port_b_pin_data_pins_oe_n_o[`PB_PUSH_PULL] <= ~port_b_direction[`PB_PUSH_PULL];
      port_b_pin_data_pins_oe_n_o[`PB_MIDDLE_OD] <= ~middle_low;
      // The delayed fall holds off only the falling edge; release stays prompt.
      if (slow_edge_enable) begin
        port_b_pin_data_pins_oe_n_o[`PB_UPPER_OD] <= ~(upper_low & upper_low_dly);
      end else begin
        port_b_pin_data_pins_oe_n_o[`PB_UPPER_OD] <= ~upper_low;
      end
      // Slew limiting of the middle pin is done by the pad driver.
      port_b_pin_data_slow_slew_o <= slow_edge_enable &
                           port_b_direction[`PB_MIDDLE_OD];
    end
  end

  // --------------------------------------------------------------------------
  // Pull devices.
  // --------------------------------------------------------------------------
  // A pull is wanted when built in, its select bit is clear, and it is either
  // a pullup or sits on an input; pulldowns would fight a driven output.
  assign pa_pull_want = PA_PULL_PRESENT & ~port_a_pull_select &
                        (PA_PULL_IS_UP | ~port_a_direction);
  assign pb_pull_want = PB_PULL_PRESENT & ~port_b_pull_select &
                        (PB_PULL_IS_UP | ~port_b_direction);

  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      port_a_pin_data_pull_on_o <= PA_PULL_PRESENT;
      port_b_pin_data_pull_on_o <= PB_PULL_PRESENT;
    end else begin
      port_a_pin_data_pull_on_o <= pa_pull_want;
      port_b_pin_data_pull_on_o <= pb_pull_want;
    end
  end

endmodule

// ----------------------------------------------------------------------------
// Three-stage pin sampler: a change counts once stages two and three agree.
// ----------------------------------------------------------------------------
module pin_sampler #(
  parameter W = 8
) (
  // Clock and reset.
  input  wire         sys_clk_i,
  input  wire         rst_i,
  // Raw pins and settled level.
  input  wire [W-1:0] pins_i,
  output reg  [W-1:0] level_o
);

  reg  [W-1:0] stage_one;
  reg  [W-1:0] stage_two;
  reg  [W-1:0] stage_three;
  wire [W-1:0] agree;

  // Only stage two reads stage one, so a metastable first stage never
  // reaches the decision. The agreement test costs a cycle but rejects
  // a level that has not yet settled.
  assign agree = stage_two ~^ stage_three;

  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      stage_one   <= {W{1'b0}};
      stage_two   <= {W{1'b0}};
      stage_three <= {W{1'b0}};
      level_o     <= {W{1'b0}};
    end else begin
      stage_one   <= pins_i;
      stage_two   <= stage_one;
      stage_three <= stage_two;
      level_o     <= (agree & stage_three) | (~agree & level_o);
    end
  end

endmodule

// >>> dv/dual_port_pin_control_assertions.sv
`timescale 1ns/10ps
module pin_control_checker #(
  parameter [7:0] PA_PULL_PRESENT = 8'hFF,
  parameter [7:0] PA_PULL_IS_UP   = 8'h00,
  parameter [2:0] PB_PULL_PRESENT = 3'h7
) (
  // Clock, reset and bus.
  input wire        sys_clk_i,
  input wire        rst_i,
  input wire        hsel_i,
  input wire [7:0]  haddr_i,
  input wire [1:0]  htrans_i,
  input wire        hwrite_i,
  input wire [31:0] hwdata_i,
  input wire        hready_i,
  input wire [31:0] hrdata_o,
  input wire        hreadyout_o,
  input wire        hresp_o,
  // Pins.
  input wire [7:0]  port_a_pin_data_pins_o,
  input wire [7:0]  port_a_pin_data_pins_oe_n_o,
  input wire [7:0]  port_a_pin_data_pull_on_o,
  input wire [2:0]  port_b_pin_data_pins_o,
  input wire [2:0]  port_b_pin_data_pins_oe_n_o,
  input wire [2:0]  port_b_pin_data_pull_on_o,
  input wire        port_b_pin_data_slow_slew_o
);
  // ----------------------------------------------------------------
  // Bus and pin relations.
  // ----------------------------------------------------------------
  wire taken = hsel_i && htrans_i[1] && hready_i;
  sequence pb_clear_two;
    taken && hwrite_i && haddr_i == 8'h04 ##1 !hwdata_i[2];
  endsequence
  ready_always_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    hreadyout_o) else $error("wait state inserted");
  resp_okay_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    !hresp_o) else $error("error response given");
  idle_rdata_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    !(taken && !hwrite_i) |=> hrdata_o == 32'h0) else $error("read data outside read");
  reset_state_a: assert property (@(posedge sys_clk_i)
    rst_i |=> port_b_pin_data_pins_oe_n_o == 3'h7 && port_a_pin_data_pins_oe_n_o == 8'hFF
      && port_a_pin_data_pull_on_o == PA_PULL_PRESENT && !port_b_pin_data_slow_slew_o)
    else $error("pins not released by reset");
  pulldown_out_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (port_a_pin_data_pull_on_o & ~port_a_pin_data_pins_oe_n_o & ~PA_PULL_IS_UP) == 8'h0)
    else $error("pulldown on a driven pin");
  pull_absent_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (port_a_pin_data_pull_on_o & ~PA_PULL_PRESENT) == 8'h0
      && (port_b_pin_data_pull_on_o & ~PB_PULL_PRESENT) == 3'h0) else $error("absent pull on");
  input_quiet_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (port_a_pin_data_pins_o & port_a_pin_data_pins_oe_n_o) == 8'h0) else $error("input pin shows data");
  drain_low_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    port_b_pin_data_pins_o[2:1] == 2'b00) else $error("open drain pin driven high");
  slow_fall_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    pb_clear_two ##0 (port_b_pin_data_slow_slew_o && port_b_pin_data_pins_oe_n_o[2])
      |=> port_b_pin_data_pins_oe_n_o[2] [*2]) else $error("upper pin fell early");
endmodule

bind dual_port_pin_control pin_control_checker #(
  .PA_PULL_PRESENT(PA_PULL_PRESENT), .PA_PULL_IS_UP(PA_PULL_IS_UP),
  .PB_PULL_PRESENT(PB_PULL_PRESENT)
) checker_u (.sys_clk_i, .rst_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i, .hwdata_i,
  .hready_i, .hrdata_o, .hreadyout_o, .hresp_o, .port_a_pin_data_pins_o, .port_a_pin_data_pins_oe_n_o,
  .port_a_pin_data_pull_on_o, .port_b_pin_data_pins_o, .port_b_pin_data_pins_oe_n_o, .port_b_pin_data_pull_on_o, .port_b_pin_data_slow_slew_o);

// >>> dv/pin_board_model.sv
`timescale 1ns/10ps
module pin_board_model #(
  parameter         W  = 8,
  parameter [W-1:0] UP = 0
) (
  // Clock and device side.
  input  wire         clk_i,
  input  wire [W-1:0] oe_n_i,
  input  wire [W-1:0] out_i,
  input  wire [W-1:0] pull_i,
  // Board drivers.
  input  wire [W-1:0] ext_i,
  input  wire [W-1:0] ext_en_i,
  output reg  [W-1:0] pin_o
);
  // ----------------------------------------------------------------
  // Pin resolution.
  // ----------------------------------------------------------------
  reg     flt = 1'b0;
  integer i;
  // A floating line toggles so that no tidy level can pass by luck.
  always @(posedge clk_i) flt <= ~flt;
  always @* begin
    for (i = 0; i < W; i = i + 1) begin
      if (!oe_n_i[i]) pin_o[i] = out_i[i];
      else if (ext_en_i[i]) pin_o[i] = ext_i[i];
      else if (pull_i[i]) pin_o[i] = UP[i];
      else pin_o[i] = flt;
    end
  end
endmodule

// >>> dv/dual_port_pin_control_tb.sv
`timescale 1ns/10ps
`include "pin_control_defines.vh"
module dual_port_pin_control_tb;
  // ----------------------------------------------------------------
  // Stimulus and wiring.
  // ----------------------------------------------------------------
  localparam [7:0] A_DAT = {`IDX_PA_DATA, 2'b00};
  localparam [7:0] B_DAT = {`IDX_PB_DATA, 2'b00};
  localparam [7:0] A_DIR = {`IDX_PA_DIR, 2'b00};
  localparam [7:0] B_DIR = {`IDX_PB_DIR, 2'b00};
  localparam [7:0] A_PUL = {`IDX_PA_PULL, 2'b00};
  localparam [7:0] B_PUL = {`IDX_PB_PULL, 2'b00};
  reg         clk = 1'b0;
  reg         rst = 1'b1;
  reg  [7:0]  haddr = 8'h00;
  reg  [1:0]  htrans = 2'b00;
  reg         hwrite = 1'b0;
  reg  [31:0] hwdata = 32'h0;
  reg  [7:0]  ext_a = 8'hA5;
  reg  [2:0]  ext_b = 3'h2;
  reg  [2:0]  ext_b_en = 3'h7;
  reg  [7:0]  ext_a_en = 8'hFF;
  reg         hsel = 1'b1;
  wire [31:0] hrdata;
  wire        hready, slow;
  wire [7:0]  pa_in, pa_out, pa_oe_n, pa_pull;
  wire [2:0]  pb_in, pb_out, pb_oe_n, pb_pull;
  integer     num_errors = 0;
  integer     samples_checked = 0;
  integer     cyc = 0;
  integer     n0, n1;
  always #10 clk = ~clk;
  dual_port_pin_control dut (.sys_clk_i(clk), .rst_i(rst), .hsel_i(hsel), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata),
    .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(),
    .port_a_pin_data_pins_i(pa_in), .port_a_pin_data_pins_o(pa_out), .port_a_pin_data_pins_oe_n_o(pa_oe_n),
    .port_a_pin_data_pull_on_o(pa_pull), .port_b_pin_data_pins_i(pb_in), .port_b_pin_data_pins_o(pb_out),
    .port_b_pin_data_pins_oe_n_o(pb_oe_n), .port_b_pin_data_pull_on_o(pb_pull), .port_b_pin_data_slow_slew_o(slow));
  pin_board_model #(.W(8), .UP(8'h00)) board_a (.clk_i(clk), .oe_n_i(pa_oe_n),
    .out_i(pa_out), .pull_i(pa_pull), .ext_i(ext_a), .ext_en_i(ext_a_en), .pin_o(pa_in));
  pin_board_model #(.W(3), .UP(3'h6)) board_b (.clk_i(clk), .oe_n_i(pb_oe_n),
    .out_i(pb_out), .pull_i(pb_pull), .ext_i(ext_b), .ext_en_i(ext_b_en), .pin_o(pb_in));
  task chk(input [31:0] g, input [31:0] e);
    begin
      samples_checked = samples_checked + 1;
      if (g !== e) begin
        num_errors = num_errors + 1;
        $display("unexpected at %0t: got %h exp %h", $time, g, e);
      end
    end
  endtask
  task xfer(input [7:0] a, input w, input [31:0] d);
    begin
      htrans <= 2'b10;
      haddr  <= a;
      hwrite <= w;
      do @(posedge clk); while (!hready);
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge clk); while (!hready);
    end
  endtask
  task wr(input [7:0] a, input [31:0] d);
    xfer(a, 1'b1, d);
  endtask
  task rd(input [7:0] a, input [31:0] e);
    begin
      xfer(a, 1'b0, 32'h0);
      chk(hrdata, e);
    end
  endtask
  task fall(output integer n);
    begin
      wr(B_DAT, 32'h3);
      n = 0;
      while (pb_oe_n[2] && n < 8) begin
        @(posedge clk);
        n = n + 1;
      end
    end
  endtask
  task results;
    begin
      $display("checks %0d errors %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
    end
  endtask
  // Cuts a hang short; the whole sequence needs about a hundred cycles.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      num_errors = num_errors + 1;
      results;
    end
  end
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    chk({pa_oe_n, pa_pull, pb_oe_n, pb_pull}, {8'hFF, 8'hFF, 3'h7, 3'h7});
    rd(B_DIR, 32'h0);
    rd(A_DAT, 32'hA5);
    wr(A_DAT, 32'h3C);
    wr(A_DIR, 32'hFFFFFFFF);
    rd(A_DIR, 32'hFF);
    ext_a <= 8'h5A;
    rd(A_DAT, 32'h3C);
    chk({pa_oe_n, pa_pull, pa_out}, {8'h00, 8'h00, 8'h3C});
    wr(B_DAT, 32'h7);
    rd(B_DAT, 32'h2);
    chk(pb_oe_n, 3'h7);
    wr(B_DIR, 32'hFFFFFFFF);
    rd(B_DIR, 32'h87);
    rd(B_DAT, 32'h7);
    chk({pb_oe_n, pb_out, pb_pull, slow}, {3'h6, 3'h1, 3'h6, 1'b1});
    wr(B_DIR, 32'h7);
    fall(n0);
    wr(B_DAT, 32'h7);
    wr(B_DIR, 32'h87);
    fall(n1);
    chk(n1, n0 + 1);
    wr(B_PUL, 32'h7);
    wr(A_PUL, 32'hFF);
    repeat (2) @(posedge clk);
    chk({pa_pull, pb_pull}, 11'h0);
    wr(B_PUL, 32'h0);
    wr(B_DIR, 32'h0);
    ext_b_en <= 3'h0;
    repeat (6) @(posedge clk);
    chk(pb_pull, 3'h7);
    rd(B_DAT, 32'h6);
    wr(8'h08, 32'hFF);
    rd(8'h08, 32'h0);
    hsel <= 1'b0;
    wr(A_DAT, 32'h0);
    hsel <= 1'b1;
    rd(A_DAT, 32'h3C);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    ext_a_en <= 8'h00;
    repeat (2) @(posedge clk);
    chk(pa_pull, 8'hFF);
    repeat (4) @(posedge clk);
    rd(A_DAT, 32'h0);
    rd(A_DIR, 32'h0);
    wr(A_DIR, 32'hFF);
    rd(A_DAT, 32'h3C);
    results;
  end
endmodule
